// ==== rtl/hot_override_params.svh ====
// constants for the forced processor hot-line pulse generator
`ifndef HOT_OVERRIDE_PARAMS_SVH
`define HOT_OVERRIDE_PARAMS_SVH

// register map
`define HOT_OVR_ADDR 8'hC6
`define HOT_OVR_RESET 8'h00
`define HOT_OVR_WMASK 8'hCF

// idle levels of the read port and of a released hot line
`define RDATA_IDLE 8'h00
`define HOT_LINE_IDLE_N 1'b1
`define HOT_LINE_IDLE_OE 1'b0

// field positions
`define DUTY_MSB 3
`define DUTY_LSB 0
`define FORCE_CPU1_BIT 6
`define FORCE_CPU2_BIT 7

// timing
`define SYS_CLK_HZ 25000000
`define TIMEBASE_HZ 22500
`define PERIOD_TICKS 80
`define STEP_TICKS 5

`endif

// ==== rtl/hot_override_pkg.sv ====
// types for the forced processor hot-line pulse generator
package hot_override_pkg;

   typedef struct packed {
      logic force_throttle_cpu2;
      logic force_throttle_cpu1;
      logic [1:0] reserved;
      logic [3:0] throttle_duty_code;
   } override_reg_s;

   typedef struct packed {
      logic cpu2_hot_line;
      logic cpu1_hot_line;
   } hot_lines_s;

endpackage

// ==== rtl/processor_hot_override_pwm.sv ====
// forced thermal-throttle pulse train on two processor hot lines
`timescale 1ns/1ps
`include "hot_override_params.svh"

module processor_hot_override_pwm #(
   parameter int SYS_CLK_HZ = `SYS_CLK_HZ,
   parameter int TIMEBASE_HZ = `TIMEBASE_HZ
) (
   // clock and reset
   input wire logic i_sys_clk,
   input wire logic i_reset_n,
   // register port
   input wire logic i_reg_wr,
   input wire logic [7:0] i_reg_addr,
   input wire logic [7:0] i_reg_wdata,
   output logic [7:0] o_reg_rdata,
   // configuration from the wider device
   input wire logic i_hot_lines_tied,
   // hot-line pins, open drain
   output hot_override_pkg::hot_lines_s o_cpu_hot_lines_n,
   output hot_override_pkg::hot_lines_s o_cpu_hot_lines_oe
);

   // ------------------------------------------------------------
   // derived timing
   // ------------------------------------------------------------
   // integer divide: timebase runs slightly fast, by about 0.01 percent
   localparam int TICK_DIV = SYS_CLK_HZ / TIMEBASE_HZ;
   localparam int DIV_W = $clog2(TICK_DIV);
   localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(TICK_DIV - 1);
   // one spare count so a full-period width fits beside the phase
   localparam int PHASE_W = $clog2(`PERIOD_TICKS + 1);
   localparam logic [PHASE_W-1:0] PHASE_LAST = PHASE_W'(`PERIOD_TICKS - 1);
   localparam logic [PHASE_W-1:0] STEP = PHASE_W'(`STEP_TICKS);
   localparam int NUM_LINES = 2;

   // ------------------------------------------------------------
   // state and wiring
   // ------------------------------------------------------------
   hot_override_pkg::override_reg_s override_reg;
   logic [7:0] read_value;
   logic [DIV_W-1:0] div_count;
   logic tick;
   logic [PHASE_W-1:0] phase;
   logic [PHASE_W-1:0] width;
   logic pulse_on;
   logic [NUM_LINES-1:0] own_force;
   logic any_force;
   wire logic [NUM_LINES-1:0] line_drive_n;
   wire logic [NUM_LINES-1:0] line_drive_oe;

   // ------------------------------------------------------------
   // override register
   // ------------------------------------------------------------
   always_ff @(posedge i_sys_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         override_reg <= `HOT_OVR_RESET;
      end
      else if (i_reg_wr && i_reg_addr == `HOT_OVR_ADDR)
      begin
         // reserved bits stay zero
         override_reg <= i_reg_wdata & `HOT_OVR_WMASK;
      end
   end

   // ------------------------------------------------------------
   // read path
   // ------------------------------------------------------------
   // only the override register answers; every other address reads zero
   always_comb
   begin
      read_value = `RDATA_IDLE;
      if (i_reg_addr == `HOT_OVR_ADDR)
      begin
         read_value = override_reg;
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         o_reg_rdata <= `RDATA_IDLE;
      end
      else
      begin
         o_reg_rdata <= read_value;
      end
   end

   // ------------------------------------------------------------
   // timebase
   // ------------------------------------------------------------
   always_ff @(posedge i_sys_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         div_count <= '0;
      end
      else if (div_count == DIV_LAST)
      begin
         div_count <= '0;
      end
      else
      begin
         div_count <= div_count + DIV_W'(1);
      end
   end

   // registered so the phase counter sees a clean one-cycle enable
   always_ff @(posedge i_sys_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         tick <= 1'b0;
      end
      else
      begin
         tick <= (div_count == DIV_LAST);
      end
   end

   // ------------------------------------------------------------
   // period
   // ------------------------------------------------------------
   // free-running phase: a new force starts mid-period, trading
   // a short first pulse for no restart logic
   always_ff @(posedge i_sys_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         phase <= '0;
      end
      else if (tick)
      begin
         if (phase == PHASE_LAST)
         begin
            phase <= '0;
         end
         else
         begin
            phase <= phase + PHASE_W'(1);
         end
      end
   end

   // ------------------------------------------------------------
   // pulse width
   // ------------------------------------------------------------
   always_comb
   begin
      width = (PHASE_W'(override_reg.throttle_duty_code) + PHASE_W'(1)) * STEP;
      pulse_on = (phase < width);
   end

   always_comb
   begin
      own_force[0] = override_reg.force_throttle_cpu1;
      own_force[1] = override_reg.force_throttle_cpu2;
      any_force = |own_force;
   end

   // ------------------------------------------------------------
   // line drive
   // ------------------------------------------------------------
   // one flop pair per pin keeps each output straight from a register
   generate
      for (genvar lane = 0; lane < NUM_LINES; lane++)
      begin : g_line
         logic request;
         logic drive_n;
         logic drive_oe;

         // tied lines share one request, so the two pins never disagree
         always_comb
         begin
            if (i_hot_lines_tied)
            begin
               request = pulse_on && any_force;
            end
            else
            begin
               request = pulse_on && own_force[lane];
            end
         end

         // drive low only while asserted, else release the pin
         always_ff @(posedge i_sys_clk or negedge i_reset_n)
         begin
            if (!i_reset_n)
            begin
               drive_n <= `HOT_LINE_IDLE_N;
               drive_oe <= `HOT_LINE_IDLE_OE;
            end
            else
            begin
               drive_n <= !request;
               drive_oe <= request;
            end
         end

         assign line_drive_n[lane] = drive_n;
         assign line_drive_oe[lane] = drive_oe;
      end
   endgenerate

   assign o_cpu_hot_lines_n = line_drive_n;
   assign o_cpu_hot_lines_oe = line_drive_oe;

endmodule

// ==== bench/hot_override_sva.sv ====
// assertions for the forced hot-line pulse generator
`timescale 1ns/1ps
module hot_override_sva (
   // clock and reset
   input wire logic i_sys_clk,
   input wire logic i_reset_n,
   // register port
   input wire logic i_reg_wr,
   input wire logic [7:0] i_reg_addr,
   input wire logic [7:0] i_reg_wdata,
   input wire logic [7:0] o_reg_rdata,
   // configuration and pins
   input wire logic i_hot_lines_tied,
   input wire hot_override_pkg::hot_lines_s o_cpu_hot_lines_n,
   input wire hot_override_pkg::hot_lines_s o_cpu_hot_lines_oe
);
   logic [7:0] shadow;
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (!i_reset_n);
   always_ff @(posedge i_sys_clk or negedge i_reset_n)
      if (!i_reset_n) shadow <= 8'h00;
      else if (i_reg_wr && i_reg_addr == 8'hc6) shadow <= i_reg_wdata & 8'hcf;
   sequence wr_then_hold;
      i_reg_wr && i_reg_addr == 8'hc6 ##1 i_reg_addr == 8'hc6;
   endsequence
   AST_READBACK: assert property (wr_then_hold |=> o_reg_rdata == ($past(i_reg_wdata, 2) & 8'hcf))
      else $error("readback mismatch");
   AST_RES_ZERO: assert property (o_reg_rdata[5:4] == 2'b00)
      else $error("reserved bits set");
   AST_UNMAPPED: assert property ($past(i_reg_addr) != 8'hc6 |-> o_reg_rdata == 8'h00)
      else $error("unmapped read not zero");
   AST_POLARITY: assert property (o_cpu_hot_lines_oe == ~o_cpu_hot_lines_n)
      else $error("enable and level disagree");
   AST_TIED: assert property ($past(i_hot_lines_tied) |-> o_cpu_hot_lines_oe[1] == o_cpu_hot_lines_oe[0])
      else $error("tied lines differ");
   AST_OFF1: assert property (!$past(shadow[6]) && !$past(i_hot_lines_tied) |-> !o_cpu_hot_lines_oe[0])
      else $error("line 1 driven unforced");
   AST_OFF2: assert property (!$past(shadow[7]) && !$past(i_hot_lines_tied) |-> !o_cpu_hot_lines_oe[1])
      else $error("line 2 driven unforced");
   AST_FULL1: assert property ($past(shadow[6]) && $past(shadow[3:0]) == 4'hf |-> o_cpu_hot_lines_oe[0])
      else $error("line 1 not held at full code");
   AST_FULL2: assert property ($past(shadow[7]) && $past(shadow[3:0]) == 4'hf |-> o_cpu_hot_lines_oe[1])
      else $error("line 2 not held at full code");
endmodule
bind processor_hot_override_pwm hot_override_sva u_sva (.i_sys_clk(i_sys_clk),
   .i_reset_n(i_reset_n), .i_reg_wr(i_reg_wr), .i_reg_addr(i_reg_addr),
   .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata), .i_hot_lines_tied(i_hot_lines_tied),
   .o_cpu_hot_lines_n(o_cpu_hot_lines_n), .o_cpu_hot_lines_oe(o_cpu_hot_lines_oe));

// ==== bench/cpu_hot_line_sink.sv ====
// open-drain hot-line wires with the board pull-up, as the processors see them
`timescale 1ns/1ps
module cpu_hot_line_sink (
   input wire logic [1:0] i_line_n,
   input wire logic [1:0] i_line_oe,
   output logic [1:0] o_pin
);
   // a released line goes to the pull-up level, never to the last driven value
   assign o_pin = ~i_line_oe | i_line_n;
endmodule

// ==== bench/processor_hot_override_pwm_tb_top.sv ====
// bench for the forced hot-line pulse generator
`timescale 1ns/1ps
module processor_hot_override_pwm_tb_top;
   logic clk = 0, rst_n = 0, wr = 0, tied = 0;
   logic [7:0] addr = 8'h00, wd = 8'h00, rd;
   logic [1:0] pin;
   hot_override_pkg::hot_lines_s hn, hoe;
   int num_errors = 0, num_checks = 0, cyc = 0, n0, n1;
   always #20 clk = ~clk;
   // timebase shrunk to 5 clocks a tick, so one period is 400 clocks
   processor_hot_override_pwm #(.TIMEBASE_HZ(5000000)) dut (.i_sys_clk(clk),
      .i_reset_n(rst_n), .i_reg_wr(wr), .i_reg_addr(addr), .i_reg_wdata(wd),
      .o_reg_rdata(rd), .i_hot_lines_tied(tied), .o_cpu_hot_lines_n(hn),
      .o_cpu_hot_lines_oe(hoe));
   cpu_hot_line_sink u_sink (.i_line_n(hn), .i_line_oe(hoe), .o_pin(pin));
   task automatic tally_and_finish();
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   always @(posedge clk) if (++cyc > 12000) begin num_errors++; tally_and_finish(); end
   task automatic wr8(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk); wr = 1; addr = a; wd = d;
      @(negedge clk); wr = 0;
   endtask
   task automatic chk(input logic [7:0] a, input logic [7:0] e);
      @(negedge clk); addr = a;
      @(negedge clk); num_checks++;
      if (rd !== e) begin num_errors++; $display("CHECK FAILED %0t rdata %h", $time, rd); end
   endtask
   // low cycles over one full period; free-running phase makes any window exact
   task automatic meas(input int e0, input int e1);
      repeat (4) @(negedge clk);
      n0 = 0; n1 = 0;
      repeat (400) @(negedge clk) begin n0 += (pin[0] === 1'b0); n1 += (pin[1] === 1'b0); end
      num_checks++;
      if (n0 != e0 || n1 != e1) begin num_errors++; $display("CHECK FAILED %0t low %0d %0d", $time, n0, n1); end
   endtask
   initial
   begin
      repeat (6) @(negedge clk);
      rst_n = 1;
      chk(8'hc6, 8'h00);
      wr8(8'hc6, 8'hff); chk(8'hc6, 8'hcf);
      wr8(8'hc5, 8'h00); chk(8'hc6, 8'hcf); chk(8'hc5, 8'h00);
      meas(400, 400);
      for (int k = 0; k < 16; k++)
      begin
         wr8(8'hc6, 8'h40 | k[7:0]); meas((k + 1) * 25, 0);
      end
      wr8(8'hc6, 8'h87); meas(0, 200);
      tied = 1; meas(200, 200);
      tied = 0; wr8(8'hc6, 8'h00); meas(0, 0);
      // mid-run reset with both lines forced must release them at once
      wr8(8'hc6, 8'hcf);
      rst_n = 0;
      @(negedge clk);
      num_checks++;
      if (pin !== 2'b11 || rd !== 8'h00) begin num_errors++; $display("CHECK FAILED %0t reset %b %h", $time, pin, rd); end
      rst_n = 1;
      chk(8'hc6, 8'h00);
      meas(0, 0);
      tally_and_finish();
   end
endmodule
